// ==== rtl/brt_map.svh ====
// Offsets, field positions, reset values and timing counts of the block
`ifndef BRT_MAP_SVH
`define BRT_MAP_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define BRT_OFS_INTERRUPT_FLAGS 15'h7ff0
`define BRT_OFS_INTERRUPT_ENABLES 15'h7ff6
`define BRT_OFS_WATCHDOG_SETTING 15'h7ff7
`define BRT_OFS_CLOCK_CONTROL 15'h7ff8
`define BRT_OFS_SECONDS_AND_HALT 15'h7ff9
`define BRT_OFS_WEEKDAY_AND_FREQ_TEST 15'h7ffc
`define BRT_OFS_CLOCK_BASE 15'h7ff0
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BRT_BIT_WATCHDOG_FLAG 7
`define BRT_BIT_ALARM_FLAG 6
`define BRT_BIT_ALARM_FLAG_ENABLE 7
`define BRT_BIT_ALARM_BACKUP_ENABLE 5
`define BRT_BIT_WATCHDOG_STEERING 7
`define BRT_BIT_WRITE_FREEZE 7
`define BRT_BIT_READ_FREEZE 6
`define BRT_BIT_CAL_SIGN 5
`define BRT_BIT_OSCILLATOR_HALT 7
`define BRT_BIT_FREQ_TEST_ENABLE 6
// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define BRT_RST_BYTE 8'h00
`define BRT_CLK_HZ 50_000_000
`define BRT_OSC_HZ 32_768
`define BRT_SEC_CYCLES 16'h8000
`define BRT_CAL_SHORT 16'h0080
`define BRT_CAL_LONG 16'h0100
`define BRT_CAL_WINDOW 6'h3e
`define BRT_FT_HALF 5'h1f
`define BRT_RST_MIN_MS 40
`define BRT_RST_MAX_MS 200
`define BRT_FLAG_DWELL_NS 15
`define BRT_FLAG_DWELL_CYC ((`BRT_FLAG_DWELL_NS * 50 + 999) / 1000)
`endif

// ==== rtl/brt_pkg.sv ====
// Types shared by the battery-backed clock and memory block
package brt_pkg;
   typedef struct packed {
      logic [14:0] addr;
      logic [7:0] dq;
      logic ce_n;
      logic oe_n;
      logic we_n;
   } brt_bus_in_t;

   typedef struct packed {
      logic [7:0] dq;
      logic dq_oe;
   } brt_bus_out_t;

   typedef struct packed {
      logic pin_o;
      logic pin_oe;
   } brt_od_pin_t;
endpackage : brt_pkg

// ==== rtl/brt_core.sv ====
// Control logic of a battery-backed static memory with real-time clock
// Overview of operation
// - Write when write strobe and select both low
// - Write spans last fall to first rise
// - Write strobe releases already-driven data outputs
// - Power fail blocks writes, floats outputs, ignores bus
// - Reset low on power fail, held 40-200 ms
// - Alarm or watchdog event sets its flag
// - Enable and steering bits gate the interrupt pin
// - Reading flag register clears flags and interrupt
// - Clear needs 15 ns stable flag address
// - Interrupt pin floats unless pending or testing
// - Read freeze stops clock register updates
// - All registers update together, never interrupted
// - Write freeze halts; clearing it by a write loads counters
// - Power-up clears both freeze bits
// - Halt bit stops oscillator; restart within second
// - Control register: five-bit magnitude plus sign
// - Calibration acts at divide-by-256 stage
// - 64-minute cycle, first 2N minutes corrected
// - Corrected second: minus 128 or plus 256
// - Pin toggles 512 Hz under frequency-test conditions
// - Power-up clears frequency-test enable
// - Steered watchdog timeout pulses reset instead
`include "brt_map.svh"
module brt_core #(
   parameter int unsigned RST_HOLD_CYC =
      `BRT_RST_MIN_MS * (`BRT_CLK_HZ / 1000)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Memory port
   input wire brt_pkg::brt_bus_in_t bus_i,
   output brt_pkg::brt_bus_out_t bus_o,
   // Supply comparators
   input wire logic power_fail_threshold,
   input wire logic battery_switch_level,
   // Event sources
   input wire logic alarm_match,
   input wire logic watchdog_timeout,
   // Open-drain pins
   output brt_pkg::brt_od_pin_t irq_or_freq_test_n,
   output brt_pkg::brt_od_pin_t reset_n
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [8:0] bcd_inc(input logic [7:0] v,
         input logic [7:0] lo, input logic [7:0] hi);
      if (v >= hi) begin
         return {1'b1, lo};
      end else if (v[3:0] == 4'h9) begin
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         return {1'b0, v + 8'h01};
      end
   endfunction : bcd_inc

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0] mem [0:32751];
   logic [7:0] cr [0:15];
   logic [7:0] tc [0:6];
   logic [14:0] addr_r;
   logic [7:0] dq_r;
   logic wr_act_r;
   logic [7:0] rd_r;
   logic pf_r;
   logic [25:0] acc_r;
   logic [15:0] osc_cnt_r;
   logic [5:0] cal_min_r;
   logic [4:0] ft_cnt_r;
   logic ft_phase_r;
   logic [3:0] dwell_r;
   logic cleared_r;
   logic [31:0] rst_cnt_r;
   logic wd_pulse_r;
   logic wd_irq_r;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire logic pf = power_fail_threshold | battery_switch_level;
   wire logic wr_act = ~bus_i.we_n & ~bus_i.ce_n & ~pf;
   wire logic rd_mode = bus_i.we_n & ~bus_i.ce_n & ~pf;
   wire logic wr_end = wr_act_r & ~wr_act;
   wire logic hit_clk = addr_r >= `BRT_OFS_CLOCK_BASE;
   wire logic [3:0] ci = addr_r[3:0];
   wire logic [7:0] flags = cr[0];
   wire logic [7:0] ien = cr[6];
   wire logic [7:0] wdog = cr[7];
   wire logic [7:0] ctl = cr[8];
   wire logic afe = ien[`BRT_BIT_ALARM_FLAG_ENABLE];
   wire logic abe = ien[`BRT_BIT_ALARM_BACKUP_ENABLE];
   wire logic watchdog_steering = wdog[`BRT_BIT_WATCHDOG_STEERING];
   wire logic wfrz = ctl[`BRT_BIT_WRITE_FREEZE];
   wire logic rfrz = ctl[`BRT_BIT_READ_FREEZE];
   wire logic halt = cr[9][`BRT_BIT_OSCILLATOR_HALT];
   wire logic ft_en = cr[12][`BRT_BIT_FREQ_TEST_ENABLE];
   wire logic wr_ctl = wr_end & (addr_r == `BRT_OFS_CLOCK_CONTROL);
   wire logic wr_wd = wr_end & (addr_r == `BRT_OFS_WATCHDOG_SETTING);
   wire logic wfrz_drop = wr_ctl & wfrz &
      ~dq_r[`BRT_BIT_WRITE_FREEZE];
   wire logic power_up = pf_r & ~pf;
   wire logic osc_tick = (acc_r + 26'(`BRT_OSC_HZ)) >= 26'(`BRT_CLK_HZ);
   wire logic osc_en = osc_tick & ~halt;
   // Calibration window: first 2N minutes of the 64-minute cycle
   wire logic cal_on = cal_min_r < {ctl[4:0], 1'b0};
   wire logic [15:0] sec_len = (cal_on && tc[0] == 8'h00) ?
      (ctl[`BRT_BIT_CAL_SIGN] ? `BRT_SEC_CYCLES + `BRT_CAL_LONG :
      `BRT_SEC_CYCLES - `BRT_CAL_SHORT) : `BRT_SEC_CYCLES;
   wire logic sec_tick = osc_en &
      (osc_cnt_r == sec_len - 16'h0001);
   wire logic upd = sec_tick & ~rfrz & ~wfrz;
   wire logic [8:0] n_sec = bcd_inc(tc[0], 8'h00, 8'h59);
   wire logic [8:0] n_min = bcd_inc(tc[1], 8'h00, 8'h59);
   wire logic [8:0] n_hr = bcd_inc(tc[2], 8'h00, 8'h23);
   wire logic [8:0] n_day = bcd_inc(tc[3], 8'h01, 8'h07);
   wire logic [8:0] n_date = bcd_inc(tc[4], 8'h01, 8'h31);
   wire logic [8:0] n_mon = bcd_inc(tc[5], 8'h01, 8'h12);
   wire logic [8:0] n_yr = bcd_inc(tc[6], 8'h00, 8'h99);
   wire logic c_min = n_sec[8];
   wire logic c_hr = c_min & n_min[8];
   wire logic c_day = c_hr & n_hr[8];
   wire logic c_mon = c_day & n_date[8];
   wire logic c_yr = c_mon & n_mon[8];
   wire logic dwell_ok = dwell_r >= 4'(`BRT_FLAG_DWELL_CYC);
   wire logic flag_clr = rd_mode & dwell_ok & ~cleared_r &
      (bus_i.addr == `BRT_OFS_INTERRUPT_FLAGS);
   wire logic wd_irq = watchdog_timeout & ~watchdog_steering;
   wire logic wd_rst = watchdog_timeout & watchdog_steering;
   wire logic irq_pend = (flags[`BRT_BIT_ALARM_FLAG] & afe &
      (~pf | abe)) | wd_irq_r;
   wire logic ft_act = ~halt & ft_en & ~afe &
      (watchdog_steering | wdog == 8'h00) & ~pf;

   // ---------------------------------------------------------------
   // Bus capture and read data
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_r <= 15'h0000;
         dq_r <= 8'h00;
         wr_act_r <= 1'b0;
         rd_r <= 8'h00;
         pf_r <= 1'b1;
      end else begin
         addr_r <= bus_i.addr;
         dq_r <= bus_i.dq;
         wr_act_r <= wr_act;
         pf_r <= pf;
         rd_r <= (bus_i.addr >= `BRT_OFS_CLOCK_BASE) ?
            cr[bus_i.addr[3:0]] : mem[bus_i.addr];
      end
   end

   // Data lands at the end of the write, when it must be valid
   always_ff @(posedge clk) begin
      if (wr_end && !hit_clk) begin
         mem[addr_r] <= dq_r;
      end
   end

   // ---------------------------------------------------------------
   // Clock byte file
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 16; i++) begin
            cr[i] <= `BRT_RST_BYTE;
         end
      end else begin
         if (wr_end && hit_clk && ci != 4'h0) begin
            cr[ci] <= dq_r;
         end
         if (upd) begin
            cr[9] <= {halt, n_sec[6:0]};
            cr[10] <= c_min ? n_min[7:0] : tc[1];
            cr[11] <= c_hr ? n_hr[7:0] : tc[2];
            cr[12] <= {1'b0, ft_en, 3'b000,
               c_day ? n_day[2:0] : tc[3][2:0]};
            cr[13] <= c_day ? n_date[7:0] : tc[4];
            cr[14] <= c_mon ? n_mon[7:0] : tc[5];
            cr[15] <= c_yr ? n_yr[7:0] : tc[6];
         end
         // Set beats clear on the flag byte
         cr[0][`BRT_BIT_ALARM_FLAG] <= alarm_match |
            (flags[`BRT_BIT_ALARM_FLAG] & ~flag_clr);
         cr[0][`BRT_BIT_WATCHDOG_FLAG] <= watchdog_timeout |
            (flags[`BRT_BIT_WATCHDOG_FLAG] & ~flag_clr);
         cr[0][5:0] <= 6'h00;
         if (wd_rst) begin
            cr[7] <= 8'h00;
            cr[12][`BRT_BIT_FREQ_TEST_ENABLE] <= 1'b0;
         end
         if (power_up) begin
            cr[6] <= `BRT_RST_BYTE;
            cr[7] <= `BRT_RST_BYTE;
            cr[8][7:6] <= 2'b00;
            cr[12][`BRT_BIT_FREQ_TEST_ENABLE] <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Time counters and divider chain
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 7; i++) begin
            tc[i] <= 8'h00;
         end
         acc_r <= 26'h000_0000;
         osc_cnt_r <= 16'h0000;
         cal_min_r <= 6'h00;
      end else begin
         acc_r <= osc_tick ? acc_r + 26'(`BRT_OSC_HZ) -
            26'(`BRT_CLK_HZ) : acc_r + 26'(`BRT_OSC_HZ);
         if (wfrz_drop) begin
            for (int i = 0; i < 7; i++) begin
               tc[i] <= cr[9 + i];
            end
            tc[0][7] <= 1'b0;
            tc[3] <= {5'h00, cr[12][2:0]};
            osc_cnt_r <= 16'h0000;
         end else if (sec_tick) begin
            osc_cnt_r <= 16'h0000;
            tc[0] <= n_sec[7:0];
            if (c_min) begin
               tc[1] <= n_min[7:0];
               cal_min_r <= cal_min_r + 6'h01;
            end
            if (c_hr) begin
               tc[2] <= n_hr[7:0];
            end
            if (c_day) begin
               tc[3] <= n_day[7:0];
               tc[4] <= n_date[7:0];
            end
            if (c_mon) begin
               tc[5] <= n_mon[7:0];
            end
            if (c_yr) begin
               tc[6] <= n_yr[7:0];
            end
         end else if (osc_en) begin
            osc_cnt_r <= osc_cnt_r + 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Frequency test, flag dwell and reset pulse
   // ---------------------------------------------------------------
   // Free-running so calibration never disturbs the 512 Hz test tone
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ft_cnt_r <= 5'h00;
         ft_phase_r <= 1'b0;
         dwell_r <= 4'h0;
         cleared_r <= 1'b0;
      end else begin
         if (osc_en) begin
            ft_cnt_r <= ft_cnt_r + 5'h01;
            if (ft_cnt_r == `BRT_FT_HALF) begin
               ft_phase_r <= ~ft_phase_r;
            end
         end
         if (rd_mode && bus_i.addr == `BRT_OFS_INTERRUPT_FLAGS) begin
            dwell_r <= dwell_ok ? dwell_r : dwell_r + 4'h1;
            cleared_r <= cleared_r | flag_clr;
         end else begin
            dwell_r <= 4'h0;
            cleared_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_cnt_r <= 32'(RST_HOLD_CYC);
         wd_pulse_r <= 1'b0;
      end else if (pf || wd_rst) begin
         rst_cnt_r <= 32'(RST_HOLD_CYC);
         wd_pulse_r <= wd_rst;
      end else if (rst_cnt_r != 32'h0000_0000) begin
         rst_cnt_r <= rst_cnt_r - 32'h0000_0001;
      end else begin
         wd_pulse_r <= 1'b0;
      end
   end

   // Steering is latched at the timeout: the steered case clears
   // the steering bit, which must not turn its flag into an interrupt
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wd_irq_r <= 1'b0;
      end else begin
         wd_irq_r <= wd_irq | (wd_irq_r & ~flag_clr);
      end
   end

   // ---------------------------------------------------------------
   // Pins
   // ---------------------------------------------------------------
   assign bus_o.dq = rd_r;
   assign bus_o.dq_oe = rd_mode & ~bus_i.oe_n;
   assign irq_or_freq_test_n.pin_o = 1'b0;
   assign irq_or_freq_test_n.pin_oe = irq_pend |
      (ft_act & ft_phase_r);
   assign reset_n.pin_o = 1'b0;
   assign reset_n.pin_oe = pf | (rst_cnt_r != 32'h0000_0000);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_flag_dwell;
      rd_mode && bus_i.addr == `BRT_OFS_INTERRUPT_FLAGS && !dwell_ok;
   endsequence

   sequence s_steered_timeout;
      wd_rst && !wd_irq_r && !flags[`BRT_BIT_ALARM_FLAG] && !alarm_match;
   endsequence

   write_frame_a: assert property (@(posedge clk) disable iff (!nrst)
      $fell(wr_act) && !hit_clk |=> mem[$past(addr_r)] == $past(dq_r))
      else $error("write data not stored");
   out_release_a: assert property (@(posedge clk) disable iff (!nrst)
      (!bus_i.we_n || pf) |-> !bus_o.dq_oe)
      else $error("data driven during write or power fail");
   pf_block_a: assert property (@(posedge clk) disable iff (!nrst)
      pf |-> !wr_act && !bus_o.dq_oe)
      else $error("bus active in power fail");
   rst_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      $fell(pf) |-> reset_n.pin_oe [*8])
      else $error("reset released too early");
   flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
      alarm_match |=> flags[`BRT_BIT_ALARM_FLAG])
      else $error("alarm flag not set");
   flag_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      flag_clr && !alarm_match && !watchdog_timeout |=>
      !flags[7] && !flags[6])
      else $error("flags not cleared");
   dwell_gate_a: assert property (@(posedge clk) disable iff (!nrst)
      s_flag_dwell |-> !flag_clr)
      else $error("clear without dwell");
   irq_gate_a: assert property (@(posedge clk) disable iff (!nrst)
      irq_or_freq_test_n.pin_oe |-> flags[6] || flags[7] || ft_act)
      else $error("interrupt pin driven without cause");
   freeze_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      rfrz && !wr_end |=> $stable(cr[9][6:0]))
      else $error("seconds changed while frozen");
   powerup_clr_a: assert property (@(posedge clk) disable iff (!nrst)
      power_up |=> !wfrz && !rfrz && !ft_en)
      else $error("freeze or test bit survived power-up");
   halt_stop_a: assert property (@(posedge clk) disable iff (!nrst)
      halt && !wfrz_drop |=> $stable(osc_cnt_r))
      else $error("oscillator ran while halted");
   wd_steer_a: assert property (@(posedge clk) disable iff (!nrst)
      wd_rst |=> reset_n.pin_oe && wd_pulse_r)
      else $error("steered timeout gave no reset");
   steer_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
      s_steered_timeout |=> !irq_or_freq_test_n.pin_oe)
      else $error("steered timeout drove interrupt pin");
   irq_latch_a: assert property (@(posedge clk) disable iff (!nrst)
      wd_irq |=> irq_or_freq_test_n.pin_oe)
      else $error("unsteered timeout gave no interrupt");
   load_time_a: assert property (@(posedge clk) disable iff (!nrst)
      wfrz_drop |=> tc[1] == $past(cr[10]) && osc_cnt_r == 16'h0000)
      else $error("freeze release did not load counters");
endmodule : brt_core

// ==== test/brt_host.sv ====
// Host processor model on the asynchronous memory port
module brt_host (
   // Clock
   input wire logic clk,
   // Memory port
   input wire brt_pkg::brt_bus_out_t bus_o,
   output brt_pkg::brt_bus_in_t bus_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      bus_i = '{15'h0000, 8'h00, 1'b1, 1'b1, 1'b1};
   end

   // --------------------------------------------------
   // Bus cycles, all changes at the falling edge
   // --------------------------------------------------
   // Released lines show inverted values, never a stale copy
   task automatic release_bus();
      bus_i = '{~bus_i.addr, ~bus_i.dq, 1'b1, 1'b1, 1'b1};
      @(negedge clk);
   endtask : release_bus

   // ce_last picks which strobe falls last and rises first
   task automatic wr(input logic [14:0] a, input logic [7:0] d,
         input logic ce_last);
      @(negedge clk);
      bus_i.addr = a;
      bus_i.dq = d;
      bus_i.we_n = ce_last ? 1'b0 : 1'b1;
      bus_i.ce_n = ce_last ? 1'b1 : 1'b0;
      @(negedge clk);
      bus_i.we_n = 1'b0;
      bus_i.ce_n = 1'b0;
      repeat (2) @(negedge clk);
      if (ce_last) begin
         bus_i.ce_n = 1'b1;
      end else begin
         bus_i.we_n = 1'b1;
      end
      @(negedge clk);
      release_bus();
   endtask : wr

   task automatic rd(input logic [14:0] a, output logic [7:0] d,
         output logic oe);
      @(negedge clk);
      bus_i.addr = a;
      bus_i.ce_n = 1'b0;
      bus_i.oe_n = 1'b0;
      // Two cycles on the address give the flag clear its dwell
      repeat (2) @(negedge clk);
      d = bus_o.dq;
      oe = bus_o.dq_oe;
      release_bus();
   endtask : rd

   // Write strobe dropped onto a read already driving the outputs
   task automatic rd_we(input logic [14:0] a, input logic [7:0] d,
         output logic oe_rd, output logic oe_wr);
      @(negedge clk);
      bus_i.addr = a;
      bus_i.dq = d;
      bus_i.ce_n = 1'b0;
      bus_i.oe_n = 1'b0;
      repeat (2) @(negedge clk);
      oe_rd = bus_o.dq_oe;
      bus_i.we_n = 1'b0;
      #1 oe_wr = bus_o.dq_oe;
      repeat (2) @(negedge clk);
      bus_i.we_n = 1'b1;
      @(negedge clk);
      release_bus();
   endtask : rd_we
endmodule : brt_host

// ==== test/brt_core_bench.sv ====
// Self-checking bench for the clock and memory control block
module brt_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 20;
   logic clk;
   logic nrst;
   logic pf_in;
   logic bsw_in;
   logic alarm_in;
   logic wdog_in;
   brt_pkg::brt_bus_in_t bus_i;
   brt_pkg::brt_bus_out_t bus_o;
   brt_pkg::brt_od_pin_t irq_pin;
   brt_pkg::brt_od_pin_t rst_pin;
   int failures = 0;
   int n_checks = 0;
   int n;
   logic [7:0] rdat;
   logic oe_a;
   logic oe_b;
   // Pull-ups on both open-drain lines
   wire irq_lvl = irq_pin.pin_oe ? irq_pin.pin_o : 1'b1;
   wire rst_lvl = rst_pin.pin_oe ? rst_pin.pin_o : 1'b1;

   brt_core #(.RST_HOLD_CYC(HOLD)) brt_core_inst (
      .clk(clk), .nrst(nrst), .bus_i(bus_i), .bus_o(bus_o),
      .power_fail_threshold(pf_in), .battery_switch_level(bsw_in),
      .alarm_match(alarm_in), .watchdog_timeout(wdog_in),
      .irq_or_freq_test_n(irq_pin), .reset_n(rst_pin));
   brt_host brt_host_inst (.clk(clk), .bus_o(bus_o), .bus_i(bus_i));

   // --------------------------------------------------
   // Compares and closing
   // --------------------------------------------------
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: byte %h not %h", $time, got, exp);
      end
   endtask : check8

   task automatic check1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: bit %b not %b", $time, got, exp);
      end
   endtask : check1

   task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
      brt_host_inst.rd(a, rdat, oe_a);
      check1(oe_a, 1'b1);
      check8(rdat, exp);
   endtask : rd_chk

   task automatic pulse(input logic wd);
      @(negedge clk);
      if (wd) begin
         wdog_in = 1'b1;
      end else begin
         alarm_in = 1'b1;
      end
      @(negedge clk);
      wdog_in = 1'b0;
      alarm_in = 1'b0;
      repeat (2) @(negedge clk);
   endtask : pulse

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Frequency test needs up to 98k of these 100k cycles
   initial begin
      #2_000_000;
      failures++;
      $display("unexpected at %0t: run hung", $time);
      complete_run();
   end

   // --------------------------------------------------
   // Tests
   // --------------------------------------------------
   initial begin
      nrst = 1'b0;
      pf_in = 1'b0;
      bsw_in = 1'b0;
      alarm_in = 1'b0;
      wdog_in = 1'b0;
      repeat (6) @(negedge clk);
      check1(rst_lvl, 1'b0);
      nrst = 1'b1;
      repeat (HOLD - 2) @(negedge clk);
      check1(rst_lvl, 1'b0);
      repeat (4) @(negedge clk);
      check1(rst_lvl, 1'b1);
      check1(irq_lvl, 1'b1);
      rd_chk(15'h7ff7, 8'h00);
      rd_chk(15'h7ff8, 8'h00);
      rd_chk(15'h7ffc, 8'h00);
      done("power_on");
      brt_host_inst.wr(15'h0123, 8'ha5, 1'b0);
      brt_host_inst.wr(15'h7fef, 8'h3c, 1'b1);
      rd_chk(15'h0123, 8'ha5);
      rd_chk(15'h7fef, 8'h3c);
      brt_host_inst.rd_we(15'h0200, 8'h5a, oe_a, oe_b);
      check1(oe_a, 1'b1);
      check1(oe_b, 1'b0);
      rd_chk(15'h0200, 8'h5a);
      done("memory");
      brt_host_inst.wr(15'h7ff0, 8'hff, 1'b0);
      rd_chk(15'h7ff0, 8'h00);
      brt_host_inst.wr(15'h7ff8, 8'h3f, 1'b0);
      rd_chk(15'h7ff8, 8'h3f);
      brt_host_inst.wr(15'h7ff8, 8'h00, 1'b0);
      pulse(1'b0);
      check1(irq_lvl, 1'b1);
      rd_chk(15'h7ff0, 8'h40);
      rd_chk(15'h7ff0, 8'h00);
      brt_host_inst.wr(15'h7ff6, 8'h80, 1'b0);
      pulse(1'b0);
      check1(irq_lvl, 1'b0);
      rd_chk(15'h7ff0, 8'h40);
      check1(irq_lvl, 1'b1);
      brt_host_inst.wr(15'h7ff6, 8'h00, 1'b0);
      done("alarm");
      pulse(1'b1);
      check1(irq_lvl, 1'b0);
      rd_chk(15'h7ff0, 8'h80);
      check1(irq_lvl, 1'b1);
      brt_host_inst.wr(15'h7ff7, 8'h80, 1'b0);
      pulse(1'b1);
      check1(rst_lvl, 1'b0);
      check1(irq_lvl, 1'b1);
      rd_chk(15'h7ff7, 8'h00);
      repeat (HOLD) @(negedge clk);
      check1(rst_lvl, 1'b1);
      rd_chk(15'h7ff0, 8'h80);
      done("watchdog");
      brt_host_inst.wr(15'h7ff8, 8'h40, 1'b0);
      @(negedge clk);
      pf_in = 1'b1;
      brt_host_inst.wr(15'h0123, 8'h11, 1'b1);
      brt_host_inst.rd(15'h0123, rdat, oe_a);
      check1(oe_a, 1'b0);
      check1(rst_lvl, 1'b0);
      pf_in = 1'b0;
      bsw_in = 1'b1;
      brt_host_inst.rd(15'h0123, rdat, oe_a);
      check1(oe_a, 1'b0);
      bsw_in = 1'b0;
      repeat (HOLD - 2) @(negedge clk);
      check1(rst_lvl, 1'b0);
      repeat (4) @(negedge clk);
      check1(rst_lvl, 1'b1);
      rd_chk(15'h0123, 8'ha5);
      rd_chk(15'h7ff8, 8'h00);
      done("power_fail");
      brt_host_inst.wr(15'h7ff8, 8'h80, 1'b0);
      brt_host_inst.wr(15'h7ffa, 8'h15, 1'b0);
      brt_host_inst.wr(15'h7ff8, 8'h00, 1'b0);
      rd_chk(15'h7ffa, 8'h15);
      done("freeze");
      // Second pass measures one full half period of the toggle
      brt_host_inst.wr(15'h7ffc, 8'h40, 1'b0);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         oe_a = irq_lvl;
         while (irq_lvl === oe_a && n < 50_000) begin
            @(negedge clk);
            n++;
         end
      end
      check1(n >= 48_826 && n <= 48_830, 1'b1);
      brt_host_inst.wr(15'h7ff9, 8'h80, 1'b0);
      check1(irq_lvl, 1'b1);
      rd_chk(15'h7ff9, 8'h80);
      done("freq_test");
      complete_run();
   end
endmodule : brt_core_bench
